// File: design/emu_map_pkg.sv
// package: constants, types and structs for the emulator mode and memory map block
package emu_map_pkg;
  // operating mode encodings
  localparam logic [2:0] MODE_EXT8 = 3'h0;
  localparam logic [2:0] MODE_EXT16 = 3'h1;
  localparam logic [2:0] MODE_EXT_ROM = 3'h2;
  localparam logic [2:0] MODE_SINGLE = 3'h3;
  localparam logic [2:0] MODE_RESET_VALUE = 3'h3;
  // 4-Gbyte space, 128-kbyte attribute granule
  localparam int ADDR_W = 32;
  localparam int GRAN_SHIFT = 17;
  localparam int MAP_IDX_W = ADDR_W - GRAN_SHIFT;
  localparam int MAP_ENTRIES = 1 << MAP_IDX_W;
  // 4 Mbytes of emulation memory in 128-kbyte units
  localparam int EMU_UNITS = 32;
  localparam int EMU_UNIT_W = 5;
  localparam int UNITS_PER_MBYTE = 8;
  // internal ranges, plain defaults
  localparam logic [31:0] IROM_BASE = 32'h0000_0000;
  localparam logic [31:0] IROM_LIMIT = 32'h0003_FFFF;
  localparam logic [31:0] IO_BASE = 32'hFFFF_8000;
  localparam logic [31:0] IO_LIMIT = 32'hFFFF_BFFF;
  localparam logic [31:0] IRAM_BASE = 32'hFFFF_C000;
  localparam logic [31:0] IRAM_LIMIT = 32'hFFFF_FFFF;
  localparam logic [7:0] WARN_INTERNAL_AREA = 8'h56; // code 86
  localparam logic [1:0] WIDTH_NONE = 2'h0;
  localparam logic [1:0] WIDTH_8 = 2'h1;
  localparam logic [1:0] WIDTH_16 = 2'h2;
  localparam logic [1:0] WIDTH_BCR = 2'h3;
  localparam logic [0:0] ONE_STATE = 1'h1;

  typedef enum logic [2:0] {
    TGT_USER = 3'b000,
    TGT_EMU = 3'b001,
    TGT_SUBROM = 3'b010,
    TGT_IRAM = 3'b011,
    TGT_IO = 3'b100
  } target_t;

  typedef enum logic [1:0] {
    RUN_HALT = 2'b00,
    RUN_EXEC = 2'b01,
    RUN_SLEEP = 2'b10
  } run_t;

  typedef struct packed {
    logic program_write_enable_pin;
    logic mode_pin_bit2;
    logic mode_pin_bit1;
    logic mode_pin_bit0;
  } mode_pins_t;

  // attribute map entry: mapped emulation unit plus attributes
  typedef struct packed {
    logic emu;
    logic wprot;
    logic guard;
    logic [EMU_UNIT_W-1:0] unit;
  } map_entry_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic dbg;
    logic [ADDR_W-1:0] addr;
  } bus_req_t;

  typedef struct packed {
    logic valid;
    target_t target;
    logic one_state;
    logic [EMU_UNIT_W-1:0] unit;
    logic block_write;
  } route_t;
endpackage

// File: design/emu_attr_mem.sv
// attribute map memory, one entry per 128-kbyte granule, registered read
`timescale 1ns/10ps
module emu_attr_mem
  import emu_map_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_we,
  input wire logic [MAP_IDX_W-1:0] i_waddr,
  input wire map_entry_t i_wdata,
  input wire logic [MAP_IDX_W-1:0] i_raddr,
  output map_entry_t o_rdata
);
  map_entry_t mem [MAP_ENTRIES];
  map_entry_t rdata_q;

  // no reset on the array; the top clears entries by sweeping
  always_ff @(posedge i_core_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    rdata_q <= mem[i_raddr];
  end

  assign o_rdata = rdata_q;
endmodule

// File: design/emu_mode_map.sv
// emulator mode selection, memory routing and low-power/interrupt supervision
// Functional notes
// - decode four valid modes from four pins
// - modes 0/1 ROM off fixed width; mode 2 register
// - mode 3 single chip, no area width
// - forced mode or user pins; forced when unattached
// - pins sampled in forced mode without effect
// - mode applies on reinitialisation; map cleared
// - 4 Mbytes placed in units; rest user
// - per-unit write-protect and guarded attributes
// - attributes only for external addresses
// - internal ROM goes to substitute RAM
// - user writes to ROM break; debugger free
// - substitute ROM accesses take one state
// - internal RAM used, one state, both masters
// - I/O always internal; attributes never break
// - debugger I/O writes unverified, warning 86
// - reject blocks mixing emulation and user memory
// - standby pin not forwarded, only monitored
// - sleep ends by wake or break, resumes next
// - debugger access during sleep clears sleep
// - no trace during sleep or halt; standby level ignored
// - latch edge interrupts while halted, service later
// - background interrupts still detect breaks
`timescale 1ns/10ps
module emu_mode_map
  import emu_map_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire mode_pins_t i_user_mode_pins,
  input wire logic i_user_attached,
  input wire logic i_force_mode_sel,
  input wire logic [2:0] i_forced_mode,
  input wire logic i_forced_pwe,
  input wire logic i_reinit,
  input wire logic i_map_we,
  input wire logic [MAP_IDX_W-1:0] i_map_idx,
  input wire logic i_map_mbyte,
  input wire map_entry_t i_map_entry,
  input wire bus_req_t i_bus_req,
  input wire logic i_hardware_standby_input,
  input wire logic i_go,
  input wire logic i_sleep_enter,
  input wire logic i_wake,
  input wire logic i_break_cond,
  input wire logic i_background,
  input wire logic i_irq_edge,
  input wire logic i_irq_taken,
  input wire logic i_trace_valid,
  output route_t o_route,
  output logic [2:0] o_mode,
  output logic o_mode_valid,
  output logic o_irom_enable,
  output logic [1:0] o_cs0_width,
  output mode_pins_t o_sampled_pins,
  output logic o_hardware_standby_input_level,
  output logic o_map_reject,
  output logic o_map_busy,
  output logic o_break,
  output logic [ADDR_W-1:0] o_violation_addr,
  output logic o_warn_valid,
  output logic [7:0] o_warn_code,
  output logic o_sleeping,
  output logic o_resume_next,
  output logic o_irq_pending,
  output logic o_trace_capture
);
  // mode state
  logic [2:0] mode_q, mode_d;
  logic pwe_q, pwe_d;
  logic valid_q, valid_d;
  logic irom_q, irom_d;
  logic [1:0] width_q, width_d;
  mode_pins_t pins_q, pins_d;
  logic hardware_standby_input_q, hardware_standby_input_d;
  logic pending_reinit_q, pending_reinit_d;
  logic [3:0] src;

  always_comb begin
    pins_d = i_user_mode_pins;
    hardware_standby_input_d = i_hardware_standby_input;
    pending_reinit_d = i_reinit;
    mode_d = mode_q;
    pwe_d = pwe_q;
    valid_d = valid_q;
    irom_d = irom_q;
    width_d = width_q;
    // forced mode ignores the pins; unattached always forces
    if (i_force_mode_sel || !i_user_attached) begin
      src = {i_forced_pwe, 1'b1, i_forced_mode[1:0]};
    end else begin
      src = i_user_mode_pins;
    end
    // mode only moves on reinitialisation
    if (pending_reinit_q) begin
      pwe_d = src[3];
      mode_d = {src[3], src[1:0]};
      valid_d = src[2] && !src[3];
      if (!src[2]) begin
        valid_d = 1'b0; // writer mode or unused code
      end
      case (src[1:0])
        2'b00: begin
          irom_d = src[3];
          width_d = src[3] ? WIDTH_BCR : WIDTH_8;
        end
        2'b01: begin
          irom_d = src[3];
          width_d = src[3] ? WIDTH_NONE : WIDTH_16;
        end
        2'b10: begin
          irom_d = 1'b1;
          width_d = WIDTH_BCR;
        end
        default: begin
          irom_d = 1'b1;
          width_d = WIDTH_NONE;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_q <= MODE_RESET_VALUE;
      pwe_q <= 1'b0;
      valid_q <= 1'b1;
      irom_q <= 1'b1;
      width_q <= WIDTH_NONE;
      pins_q <= '0;
      hardware_standby_input_q <= 1'b0;
      pending_reinit_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      pwe_q <= pwe_d;
      valid_q <= valid_d;
      irom_q <= irom_d;
      width_q <= width_d;
      pins_q <= pins_d;
      hardware_standby_input_q <= hardware_standby_input_d;
      pending_reinit_q <= pending_reinit_d;
    end
  end

  // attribute map with clear sweep and mix check
  logic clr_q, clr_d;
  logic [MAP_IDX_W-1:0] clr_idx_q, clr_idx_d;
  logic [2:0] sub_q, sub_d;
  logic burst_q, burst_d;
  logic [MAP_IDX_W-1:0] burst_idx_q, burst_idx_d;
  map_entry_t burst_ent_q, burst_ent_d;
  logic reject_q, reject_d;
  logic busy_q, busy_d;
  logic mem_we;
  logic [MAP_IDX_W-1:0] mem_waddr;
  map_entry_t mem_wdata;
  map_entry_t rd_entry;

  always_comb begin
    clr_d = clr_q;
    clr_idx_d = clr_idx_q;
    sub_d = sub_q;
    burst_d = burst_q;
    burst_idx_d = burst_idx_q;
    burst_ent_d = burst_ent_q;
    reject_d = 1'b0;
    mem_we = 1'b0;
    mem_waddr = clr_idx_q;
    mem_wdata = '0;
    if (i_reinit) begin
      clr_d = 1'b1;
      clr_idx_d = '0;
      burst_d = 1'b0;
    end else if (clr_q) begin
      mem_we = 1'b1;
      clr_idx_d = clr_idx_q + 1'b1;
      if (&clr_idx_q) begin
        clr_d = 1'b0;
      end
    end else if (burst_q) begin
      // 1-Mbyte unit written as eight 128-kbyte entries
      mem_we = 1'b1;
      mem_waddr = {burst_idx_q[MAP_IDX_W-1:3], sub_q};
      mem_wdata = burst_ent_q;
      mem_wdata.unit = {burst_ent_q.unit[EMU_UNIT_W-1:3], sub_q};
      sub_d = sub_q + 1'b1;
      if (&sub_q) begin
        burst_d = 1'b0;
      end
    end else if (i_map_we) begin
      // a block entry that claims user memory but carries attributes is mixed
      if (!i_map_entry.emu && (i_map_entry.wprot || i_map_entry.guard)) begin
        reject_d = 1'b1;
      end else if (i_map_mbyte) begin
        burst_d = 1'b1;
        burst_idx_d = i_map_idx;
        burst_ent_d = i_map_entry;
        sub_d = '0;
      end else begin
        mem_we = 1'b1;
        mem_waddr = i_map_idx;
        mem_wdata = i_map_entry;
      end
    end
    // busy kept in its own flop so the port needs no gate after the registers
    busy_d = clr_d | burst_d;
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      clr_q <= 1'b1;
      clr_idx_q <= '0;
      sub_q <= '0;
      burst_q <= 1'b0;
      burst_idx_q <= '0;
      burst_ent_q <= '0;
      reject_q <= 1'b0;
      busy_q <= 1'b1;
    end else begin
      clr_q <= clr_d;
      clr_idx_q <= clr_idx_d;
      sub_q <= sub_d;
      burst_q <= burst_d;
      burst_idx_q <= burst_idx_d;
      burst_ent_q <= burst_ent_d;
      reject_q <= reject_d;
      busy_q <= busy_d;
    end
  end

  emu_attr_mem u_attr_mem (
    .i_core_clk(i_core_clk),
    .i_we(mem_we),
    .i_waddr(mem_waddr),
    .i_wdata(mem_wdata),
    .i_raddr(i_bus_req.addr[ADDR_W-1:GRAN_SHIFT]),
    .o_rdata(rd_entry)
  );

  // access routing: table read takes one cycle, request staged alongside
  bus_req_t req_q, req_d;
  route_t route_q, route_d;
  logic brk_q, brk_d;
  logic [ADDR_W-1:0] vaddr_q, vaddr_d;
  logic warn_q, warn_d;
  logic in_rom, in_ram, in_io;
  run_t run_q, run_d;
  logic resume_q, resume_d;
  logic irq_q, irq_d;
  logic trace_q, trace_d;
  logic sleep_q, sleep_d;

  always_comb begin
    req_d = i_bus_req;
    route_d = '0;
    brk_d = 1'b0;
    vaddr_d = vaddr_q;
    warn_d = 1'b0;
    in_rom = irom_q && req_q.addr >= IROM_BASE && req_q.addr <= IROM_LIMIT;
    in_io = req_q.addr >= IO_BASE && req_q.addr <= IO_LIMIT;
    in_ram = req_q.addr >= IRAM_BASE && req_q.addr <= IRAM_LIMIT;
    if (req_q.valid && !clr_q) begin
      route_d.valid = 1'b1;
      if (in_rom) begin
        route_d.target = TGT_SUBROM;
        route_d.one_state = ONE_STATE[0];
        if (req_q.write && !req_q.dbg) begin
          route_d.block_write = 1'b1;
          brk_d = 1'b1;
        end
      end else if (in_ram) begin
        route_d.target = TGT_IRAM;
        route_d.one_state = ONE_STATE[0];
      end else if (in_io) begin
        route_d.target = TGT_IO;
        warn_d = req_q.write && req_q.dbg;
      end else if (rd_entry.emu) begin
        // attribute checks here only, background loop included
        route_d.target = TGT_EMU;
        route_d.unit = rd_entry.unit;
        if (!req_q.dbg && (rd_entry.guard || (req_q.write && rd_entry.wprot))) begin
          route_d.block_write = req_q.write;
          brk_d = 1'b1;
        end
      end else begin
        route_d.target = TGT_USER;
      end
    end
    if (brk_d) begin
      vaddr_d = req_q.addr;
    end
  end

  always_comb begin
    run_d = run_q;
    resume_d = 1'b0;
    irq_d = irq_q;
    case (run_q)
      RUN_HALT: begin
        if (i_go) begin
          run_d = RUN_EXEC;
        end
      end
      RUN_EXEC: begin
        if (i_break_cond || brk_q) begin
          run_d = RUN_HALT;
        end else if (i_sleep_enter) begin
          run_d = RUN_SLEEP;
        end
      end
      RUN_SLEEP: begin
        if (i_break_cond) begin
          run_d = RUN_HALT;
          resume_d = 1'b1;
        end else if (i_wake || (i_bus_req.valid && i_bus_req.dbg)) begin
          run_d = RUN_EXEC;
          resume_d = 1'b1;
        end
      end
      default: begin
        run_d = RUN_HALT;
      end
    endcase
    // capture wins over service in the same cycle
    if (i_irq_taken && run_q == RUN_EXEC) begin
      irq_d = 1'b0;
    end
    if (i_irq_edge && run_q == RUN_HALT && !i_background) begin
      irq_d = 1'b1;
    end
    trace_d = i_trace_valid && run_q == RUN_EXEC && !i_background;
    sleep_d = (run_d == RUN_SLEEP);
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      req_q <= '0;
      route_q <= '0;
      brk_q <= 1'b0;
      vaddr_q <= '0;
      warn_q <= 1'b0;
      run_q <= RUN_HALT;
      resume_q <= 1'b0;
      irq_q <= 1'b0;
      trace_q <= 1'b0;
      sleep_q <= 1'b0;
    end else begin
      req_q <= req_d;
      route_q <= route_d;
      brk_q <= brk_d;
      vaddr_q <= vaddr_d;
      warn_q <= warn_d;
      run_q <= run_d;
      resume_q <= resume_d;
      irq_q <= irq_d;
      trace_q <= trace_d;
      sleep_q <= sleep_d;
    end
  end

  assign o_route = route_q;
  assign o_mode = mode_q;
  assign o_mode_valid = valid_q;
  assign o_irom_enable = irom_q;
  assign o_cs0_width = width_q;
  assign o_sampled_pins = pins_q;
  assign o_hardware_standby_input_level = hardware_standby_input_q;
  assign o_map_reject = reject_q;
  assign o_map_busy = busy_q;
  assign o_break = brk_q;
  assign o_violation_addr = vaddr_q;
  assign o_warn_valid = warn_q;
  assign o_warn_code = WARN_INTERNAL_AREA;
  assign o_sleeping = sleep_q;
  assign o_resume_next = resume_q;
  assign o_irq_pending = irq_q;
  assign o_trace_capture = trace_q;
endmodule

// File: tb/user_sys_model.sv
// user system side: mode pins and standby level, pulled high when unplugged
`timescale 1ns/10ps
module user_sys_model
  import emu_map_pkg::*;
(
  input wire logic i_attach,
  input wire mode_pins_t i_pins,
  input wire logic i_stby,
  output mode_pins_t o_pins,
  output logic o_attached,
  output logic o_stby
);
  // pull-ups turn floating pins high, so an empty socket reads all ones
  assign o_pins = i_attach ? i_pins : 4'hF;
  assign o_stby = i_attach ? i_stby : 1'h1;
  assign o_attached = i_attach;
endmodule

// File: tb/emu_mode_map_properties.sv
// concurrent checks on the mode and memory map ports
`timescale 1ns/10ps
module emu_mode_map_properties
  import emu_map_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_reinit,
  input wire logic i_map_we,
  input wire map_entry_t i_map_entry,
  input wire bus_req_t i_bus_req,
  input wire route_t o_route,
  input wire logic [2:0] o_mode,
  input wire logic o_mode_valid,
  input wire logic o_irom_enable,
  input wire logic [1:0] o_cs0_width,
  input wire logic o_map_reject,
  input wire logic o_map_busy,
  input wire logic o_break,
  input wire logic o_warn_valid,
  input wire logic [7:0] o_warn_code,
  input wire logic o_sleeping,
  input wire logic o_resume_next,
  input wire logic o_trace_capture
);
  logic req, rom_a, io_a, ram_a, mixed, wr_dbg;
  logic [1:0] exp_w;
  // requests during the clear sweep are dropped, so they expect nothing
  assign req = i_bus_req.valid && !o_map_busy && !i_reinit;
  assign rom_a = i_bus_req.addr <= IROM_LIMIT;
  assign io_a = i_bus_req.addr >= IO_BASE && i_bus_req.addr <= IO_LIMIT;
  assign ram_a = i_bus_req.addr >= IRAM_BASE;
  assign mixed = !i_map_entry.emu && (i_map_entry.wprot || i_map_entry.guard);
  assign wr_dbg = i_bus_req.dbg;
  assign exp_w = o_mode[1] ? (o_mode[0] ? WIDTH_NONE : WIDTH_BCR) :
    (o_mode[0] ? WIDTH_16 : WIDTH_8);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  a_mode_width: assert property (
    o_mode_valid |-> o_cs0_width == exp_w && o_irom_enable == o_mode[1])
    else $error("width or rom enable wrong");
  a_mixed_reject: assert property (
    i_map_we && !o_map_busy && !i_reinit |=> o_map_reject == $past(mixed))
    else $error("map reject wrong");
  a_rom_sub: assert property (
    req && rom_a && o_irom_enable |-> ##2 o_route.valid && o_route.target == TGT_SUBROM
    && o_route.one_state) else $error("rom access not on substitute");
  a_rom_write: assert property (
    req && rom_a && o_irom_enable && i_bus_req.write |-> ##2 o_break != $past(wr_dbg, 2))
    else $error("rom write break wrong");
  a_ram_fast: assert property (
    req && ram_a |-> ##2 o_route.target == TGT_IRAM && o_route.one_state && !o_break)
    else $error("ram access wrong");
  a_io_inside: assert property (
    req && io_a |-> ##2 o_route.target == TGT_IO && !o_break)
    else $error("io access wrong");
  a_io_warn: assert property (
    req && io_a && i_bus_req.write && i_bus_req.dbg |-> ##2 o_warn_valid
    && o_warn_code == WARN_INTERNAL_AREA) else $error("io warning missing");
  a_sleep_trace: assert property (
    o_sleeping && $past(o_sleeping) |-> !o_trace_capture)
    else $error("trace during sleep");
  a_dbg_wake: assert property (
    o_sleeping && req && i_bus_req.dbg |-> ##[1:2] o_resume_next && !o_sleeping)
    else $error("debug access kept sleep");
  c_break: cover property (o_break);
  c_reject: cover property (o_map_reject);
  c_resume: cover property (o_resume_next);
endmodule

// File: tb/tb.sv
// bench for the emulator mode and memory map block
`timescale 1ns/10ps
module tb;
  import emu_map_pkg::*;
  logic i_core_clk = 1'h0, i_arst_n = 1'h0, att = 1'h1, stby = 1'h1;
  mode_pins_t pins = 4'h7;
  mode_pins_t i_user_mode_pins, o_sampled_pins;
  logic i_user_attached, i_hardware_standby_input;
  logic i_force_mode_sel = 1'h0, i_forced_pwe = 1'h0, i_reinit = 1'h0;
  logic [2:0] i_forced_mode = 3'h7, prev_mode = 3'h3;
  logic i_map_we = 1'h0, i_map_mbyte = 1'h0;
  logic [MAP_IDX_W-1:0] i_map_idx = '0;
  map_entry_t i_map_entry = '0;
  bus_req_t i_bus_req = '0;
  logic i_go = 1'h0, i_sleep_enter = 1'h0, i_wake = 1'h0, i_break_cond = 1'h0;
  logic i_background = 1'h0, i_irq_edge = 1'h0, i_irq_taken = 1'h0, i_trace_valid = 1'h1;
  route_t o_route;
  logic [2:0] o_mode;
  logic [1:0] o_cs0_width;
  logic [ADDR_W-1:0] o_violation_addr;
  logic [7:0] o_warn_code;
  logic o_mode_valid, o_irom_enable, o_hardware_standby_input_level, o_map_reject, o_map_busy, o_break;
  logic o_warn_valid, o_sleeping, o_resume_next, o_irq_pending, o_trace_capture;
  int err_total = 0, tests_run = 0, cycles = 0;
  user_sys_model sys_u (.i_attach(att), .i_pins(pins), .i_stby(stby),
    .o_pins(i_user_mode_pins), .o_attached(i_user_attached), .o_stby(i_hardware_standby_input));
  emu_mode_map dut_u (.i_core_clk, .i_arst_n, .i_user_mode_pins, .i_user_attached,
    .i_force_mode_sel, .i_forced_mode, .i_forced_pwe, .i_reinit, .i_map_we, .i_map_idx,
    .i_map_mbyte, .i_map_entry, .i_bus_req, .i_hardware_standby_input, .i_go, .i_sleep_enter,
    .i_wake, .i_break_cond, .i_background, .i_irq_edge, .i_irq_taken, .i_trace_valid, .o_route,
    .o_mode, .o_mode_valid, .o_irom_enable, .o_cs0_width, .o_sampled_pins, .o_hardware_standby_input_level,
    .o_map_reject, .o_map_busy, .o_break, .o_violation_addr, .o_warn_valid, .o_warn_code,
    .o_sleeping, .o_resume_next, .o_irq_pending, .o_trace_capture);
  initial forever #20 i_core_clk = ~i_core_clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  task automatic idle();
    while (o_map_busy !== 1'h0) begin
      cyc(1);
      #1;
    end
  endtask
  task automatic mapw(input logic [14:0] idx, input logic mb, input logic [2:0] attr,
    input logic [4:0] u, input logic rej);
    cyc(1);
    i_map_we <= 1'h1;
    i_map_idx <= idx;
    i_map_mbyte <= mb;
    i_map_entry <= {attr, u};
    cyc(1);
    i_map_we <= 1'h0;
    #1;
    chk(o_map_reject, rej);
    idle();
  endtask
  task automatic acc(input logic go, input logic wr, input logic dbg, input logic [31:0] a,
    input target_t t, input logic brk, input logic [4:0] u);
    cyc(1);
    i_go <= go;
    cyc(1);
    i_go <= 1'h0;
    i_bus_req <= '{1'h1, wr, dbg, a};
    cyc(1);
    i_bus_req.valid <= 1'h0;
    cyc(1);
    #1;
    chk(o_route.valid, 1'h1);
    chk(o_route.target, t);
    chk(o_break, brk);
    chk(o_route.block_write, brk && wr);
    chk(o_warn_valid, wr && dbg && t == TGT_IO);
    if (t == TGT_SUBROM || t == TGT_IRAM) chk(o_route.one_state, 1'h1);
    if (u != 5'h00) chk(o_route.unit, u);
  endtask
  task automatic rmode(input logic fs, input logic at, input logic [2:0] fm,
    input logic [3:0] p, input logic [2:0] m, input logic v, input logic [1:0] w);
    cyc(1);
    i_force_mode_sel <= fs;
    att <= at;
    i_forced_pwe <= fm[2];
    i_forced_mode <= {1'h1, fm[1:0]};
    pins <= p;
    cyc(2);
    #1;
    chk(o_mode, prev_mode);
    chk(o_sampled_pins, at ? p : 4'hF);
    cyc(1);
    i_reinit <= 1'h1;
    cyc(1);
    i_reinit <= 1'h0;
    cyc(2);
    #1;
    chk(o_mode, m);
    chk(o_mode_valid, v);
    if (v) chk(o_cs0_width, w);
    prev_mode = m;
  endtask
  task automatic slp(input int how);
    logic seen;
    cyc(1);
    i_go <= 1'h1;
    cyc(1);
    i_go <= 1'h0;
    i_sleep_enter <= 1'h1;
    cyc(1);
    i_sleep_enter <= 1'h0;
    cyc(2);
    #1;
    chk(o_sleeping, 1'h1);
    chk(o_trace_capture, 1'h0);
    cyc(1);
    if (how == 0) i_bus_req <= '{1'h1, 1'h0, 1'h1, IRAM_BASE};
    else if (how == 1) i_break_cond <= 1'h1;
    else i_wake <= 1'h1;
    cyc(1);
    i_bus_req.valid <= 1'h0;
    i_break_cond <= 1'h0;
    i_wake <= 1'h0;
    seen = 1'h0;
    repeat (3) begin
      #1;
      if (o_resume_next === 1'h1) seen = 1'h1;
      cyc(1);
    end
    chk(seen, 1'h1);
    #1;
    chk(o_sleeping, 1'h0);
    chk(o_trace_capture, how != 1);
  endtask
  always @(posedge i_core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    cyc(10);
    i_arst_n <= 1'h1;
    #1;
    chk(o_mode, MODE_RESET_VALUE);
    chk(o_map_busy, 1'h1);
    idle();
    mapw(15'h0100, 1'h0, 3'h6, 5'h05, 1'h0);
    mapw(15'h0101, 1'h0, 3'h5, 5'h06, 1'h0);
    mapw(15'h0102, 1'h0, 3'h1, 5'h07, 1'h1);
    mapw(15'h0103, 1'h0, 3'h2, 5'h07, 1'h1);
    mapw(15'h0104, 1'h0, 3'h4, 5'h07, 1'h0);
    mapw(15'h0108, 1'h1, 3'h6, 5'h08, 1'h0);
    mapw(15'h7FFF, 1'h0, 3'h5, 5'h09, 1'h0);
    acc(1'h1, 1'h0, 1'h0, 32'h0000_0100, TGT_SUBROM, 1'h0, 5'h00);
    acc(1'h1, 1'h1, 1'h0, 32'h0003_FFFC, TGT_SUBROM, 1'h1, 5'h00);
    acc(1'h0, 1'h1, 1'h1, 32'h0000_0100, TGT_SUBROM, 1'h0, 5'h00);
    acc(1'h1, 1'h0, 1'h0, IRAM_BASE, TGT_IRAM, 1'h0, 5'h00);
    acc(1'h0, 1'h1, 1'h1, 32'hFFFF_FFFC, TGT_IRAM, 1'h0, 5'h00);
    acc(1'h1, 1'h1, 1'h0, IO_BASE, TGT_IO, 1'h0, 5'h00);
    acc(1'h0, 1'h1, 1'h1, IO_LIMIT, TGT_IO, 1'h0, 5'h00);
    acc(1'h1, 1'h0, 1'h0, 32'hFFFE_0000, TGT_EMU, 1'h1, 5'h09);
    acc(1'h1, 1'h1, 1'h0, 32'h0200_0000, TGT_EMU, 1'h1, 5'h05);
    chk(o_violation_addr, 32'h0200_0000);
    acc(1'h1, 1'h0, 1'h0, 32'h0200_0004, TGT_EMU, 1'h0, 5'h05);
    acc(1'h1, 1'h0, 1'h0, 32'h0202_0010, TGT_EMU, 1'h1, 5'h06);
    acc(1'h1, 1'h0, 1'h0, 32'h0204_0000, TGT_USER, 1'h0, 5'h00);
    acc(1'h1, 1'h1, 1'h0, 32'h0208_0000, TGT_EMU, 1'h0, 5'h07);
    acc(1'h1, 1'h1, 1'h0, 32'h021E_0000, TGT_EMU, 1'h1, 5'h0F);
    acc(1'h1, 1'h1, 1'h0, 32'h0220_0000, TGT_USER, 1'h0, 5'h00);
    cyc(1);
    i_background <= 1'h1;
    acc(1'h1, 1'h0, 1'h0, 32'h0202_0000, TGT_EMU, 1'h1, 5'h06);
    cyc(1);
    i_background <= 1'h0;
    slp(0);
    slp(2);
    slp(1);
    cyc(1);
    i_irq_edge <= 1'h1;
    cyc(1);
    i_irq_edge <= 1'h0;
    i_go <= 1'h1;
    cyc(1);
    i_go <= 1'h0;
    #1;
    chk(o_irq_pending, 1'h1);
    cyc(1);
    i_irq_taken <= 1'h1;
    cyc(1);
    i_irq_taken <= 1'h0;
    cyc(1);
    #1;
    chk(o_irq_pending, 1'h0);
    cyc(1);
    stby <= 1'h0;
    cyc(2);
    #1;
    chk(o_hardware_standby_input_level, 1'h0);
    rmode(1'h1, 1'h1, 3'h0, 4'h6, 3'h0, 1'h1, WIDTH_8);
    rmode(1'h1, 1'h1, 3'h1, 4'h6, 3'h1, 1'h1, WIDTH_16);
    rmode(1'h0, 1'h1, 3'h3, 4'h6, 3'h2, 1'h1, WIDTH_BCR);
    rmode(1'h0, 1'h1, 3'h3, 4'hE, 3'h6, 1'h0, WIDTH_BCR);
    rmode(1'h0, 1'h0, 3'h3, 4'h5, 3'h3, 1'h1, WIDTH_NONE);
    idle();
    acc(1'h1, 1'h1, 1'h0, 32'h0200_0000, TGT_USER, 1'h0, 5'h00);
    finish_test();
  end
endmodule
bind emu_mode_map emu_mode_map_properties chk_u (.i_core_clk, .i_arst_n, .i_reinit, .i_map_we,
  .i_map_entry, .i_bus_req, .o_route, .o_mode, .o_mode_valid, .o_irom_enable, .o_cs0_width,
  .o_map_reject, .o_map_busy, .o_break, .o_warn_valid, .o_warn_code, .o_sleeping,
  .o_resume_next, .o_trace_capture);
